// >>> pkg/ichf_regs.vh
// constants for the correlation header framer: offsets, field positions, reset values
`ifndef ICHF_REGS_VH
`define ICHF_REGS_VH
// header layout
`define ICHF_HDR_LEN 5'h14
`define ICHF_HDR_LAST 5'h13
`define ICHF_VERSION 3'h0
`define ICHF_MSG_TYPE 8'hFF
`define ICHF_FILL_ZERO 8'h00
`define ICHF_FILL_ONES 8'hFF
`define ICHF_B1_VER_MSB 7
`define ICHF_B1_VER_LSB 5
`define ICHF_B1_FIXED1 4
`define ICHF_B1_SPARE 3
`define ICHF_B1_ICE 2
`define ICHF_B1_DIR 1
`define ICHF_B1_FIXED0 0
// register map (byte addresses)
`define ICHF_REG_CTRL 8'h00
`define ICHF_REG_STATUS 8'h04
`define ICHF_REG_NODE_ID 8'h08
`define ICHF_REG_SEQ 8'h0C
`define ICHF_REG_COUNT 8'h10
`define ICHF_REG_DROP 8'h14
`define ICHF_CTRL_EN 0
`define ICHF_CTRL_SEQ_CLR 1
`define ICHF_CTRL_DROP_MODE 2
`define ICHF_CTRL_RESET 32'h0000_0001
`define ICHF_NODE_ID_RESET 32'h0000_0000
// fifo
`define ICHF_FIFO_WIDTH 9
`define ICHF_FIFO_DEPTH 8
`define ICHF_FIFO_AW 3
`endif

// >>> src/ichf_fifo.v
// synchronous valid/ready fifo with parameterised width and depth
`timescale 1ns/100ps
`default_nettype none
module ichf_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	////////////////////////////////////////////////////////////////
	// honest full and empty from the occupancy count
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_q];
	assign push = ce & in_valid & in_ready;
	assign pop = ce & out_valid & out_ready;

	// storage has no reset; only pointers matter
	always @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	// pointers and count
	always @(posedge clk)
	begin
		if (rst)
		begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // ichf_fifo
`default_nettype wire

// >>> src/ichf_ahb_regs.v
// ahb-lite slave holding control, node identifier and status registers
`timescale 1ns/100ps
`default_nettype none
`include "ichf_regs.vh"
module ichf_ahb_regs (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] ctrl,
	output wire [31:0] node_id,
	output wire seq_clr,
	input wire [31:0] status,
	input wire [15:0] seq_now,
	input wire [31:0] pkt_count,
	input wire [31:0] drop_count
);
	reg [31:0] ctrl_q;
	reg [31:0] node_id_q;
	reg wr_pend_q;
	reg [7:0] wr_addr_q;
	reg seq_clr_q;
	wire take;

	////////////////////////////////////////////////////////////////
	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign take = ce & hsel & hready & htrans[1];
	assign ctrl = ctrl_q;
	assign node_id = node_id_q;
	assign seq_clr = seq_clr_q;

	// address phase capture and write data phase
	always @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_q <= `ICHF_CTRL_RESET;
			node_id_q <= `ICHF_NODE_ID_RESET;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			seq_clr_q <= 1'b0;
		end
		else if (ce)
		begin
			seq_clr_q <= 1'b0;
			if (wr_pend_q)
			begin
				// seq clear bit is a self-clearing pulse, never stored
				if (wr_addr_q == `ICHF_REG_CTRL)
				begin
					ctrl_q <= hwdata & 32'h0000_0005;
					seq_clr_q <= hwdata[`ICHF_CTRL_SEQ_CLR];
				end
				else if (wr_addr_q == `ICHF_REG_NODE_ID)
					node_id_q <= hwdata;
			end
			wr_pend_q <= take & hwrite;
			wr_addr_q <= haddr;
		end
	end

	// read data registered at address phase so it stands in the data phase
	always @(posedge clk)
	begin
		if (rst)
			hrdata <= 32'h0000_0000;
		else if (take & ~hwrite)
		begin
			case (haddr)
				`ICHF_REG_CTRL: hrdata <= ctrl_q;
				`ICHF_REG_STATUS: hrdata <= status;
				`ICHF_REG_NODE_ID: hrdata <= node_id_q;
				`ICHF_REG_SEQ: hrdata <= {16'h0000, seq_now};
				`ICHF_REG_COUNT: hrdata <= pkt_count;
				`ICHF_REG_DROP: hrdata <= drop_count;
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // ichf_ahb_regs
`default_nettype wire

// >>> src/ichf_framer.v
// correlation header framer: prefixes each intercepted packet that is not dropped with a 20-octet header
// Functional notes
// [RL1] the version field in bits 8..6 of octet 1 carries zero.
// [RL2] octet 1 bit 5 is one, spare bit 4 is one and bit 1 is zero in every header.
// [RL3] the direction bit is one for uplink packets from the user and zero for downlink.
// [RL4] octet 2 always carries the message type 255.
// [RL5] octets 3-4 carry the payload length in octets, excluding the header, msb first.
// [RL6] octets 5-6 carry a sequence number that increases per packet, msb first.
// [RL7] octets 7 and 8 carry zero.
// [RL8] octets 9 to 12 each carry 255.
// [RL9] octets 13-20 carry the correlation number: node identifier then 4-octet billing tag.
// [RL10] the element type bit is zero for gateway node capture and one for serving node capture.
// [RL11] each header is followed by exactly one payload element.
// [RL12] the payload element is the complete intercepted packet, header and payload.
// [RL13] every framed packet is handed to the transport output for udp or tcp delivery.
// [RL14] in udp mode the framer never waits on or retries for the far end; packets may be lost. Here a fifo full at packet start drops; later it stalls.
// [RL15] the monitoring facility orders stored packets by sequence number and correlates by number.
// [RL16] the monitoring facility must not assume contiguous numbering across a handoff.
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "ichf_regs.vh"
module ichf_framer (
	input wire CLOCK,
	input wire RST,
	input wire CE,
	// ahb-lite slave
	input wire HSEL,
	input wire [7:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output wire [31:0] HRDATA,
	output wire HREADYOUT,
	output wire HRESP,
	// packet metadata, taken when the first payload octet is first offered in idle, before that octet is accepted
	input wire META_UPLINK,
	input wire META_SERVING_NODE,
	input wire [15:0] META_LENGTH,
	input wire [31:0] META_BILLING_TAG,
	// intercepted packet octets
	input wire IN_VALID,
	output wire IN_READY,
	input wire [7:0] IN_DATA,
	input wire IN_LAST,
	// framed stream to the transport
	output wire OUT_VALID,
	input wire OUT_READY,
	output wire [7:0] OUT_DATA,
	output wire OUT_LAST,
	output wire BUSY
);
	localparam ST_IDLE = 2'h0;
	localparam ST_HDR = 2'h1;
	localparam ST_PAY = 2'h2;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [4:0] idx_q;
	reg [15:0] seq_q;
	reg [7:0] b1_q;
	reg [15:0] len_q;
	reg [31:0] tag_q;
	reg [31:0] pkt_count_q;
	reg [31:0] drop_count_q;
	reg [7:0] hdr_byte;
	reg [8:0] f_data;
	reg f_valid;
	reg drop_q;
	wire f_ready;
	wire [8:0] o_data;
	wire o_valid;
	wire [31:0] ctrl;
	wire [31:0] node_id;
	wire seq_clr;
	wire enable;
	wire drop_mode;
	wire start;
	wire hdr_step;
	wire pay_step;
	wire [31:0] status;

	////////////////////////////////////////////////////////////////
	// register slave
	ichf_ahb_regs u_regs (
		.clk(CLOCK),
		.rst(RST),
		.ce(CE),
		.hsel(HSEL),
		.haddr(HADDR),
		.htrans(HTRANS),
		.hwrite(HWRITE),
		.hsize(HSIZE),
		.hwdata(HWDATA),
		.hready(HREADY),
		.hrdata(HRDATA),
		.hreadyout(HREADYOUT),
		.hresp(HRESP),
		.ctrl(ctrl),
		.node_id(node_id),
		.seq_clr(seq_clr),
		.status(status),
		.seq_now(seq_q),
		.pkt_count(pkt_count_q),
		.drop_count(drop_count_q)
	);

	assign enable = ctrl[`ICHF_CTRL_EN];
	assign drop_mode = ctrl[`ICHF_CTRL_DROP_MODE];
	assign status = {29'h0000_0000, ~o_valid, state_q};
	assign BUSY = (state_q != ST_IDLE);

	////////////////////////////////////////////////////////////////
	// first octet and field capture; metadata latched once per packet
	assign start = CE & enable & (state_q == ST_IDLE) & IN_VALID;
	assign hdr_step = CE & (state_q == ST_HDR) & (f_ready | drop_q);
	assign pay_step = CE & (state_q == ST_PAY) & IN_VALID & (f_ready | drop_q);

	always @(posedge CLOCK)
	begin
		if (RST)
		begin
			b1_q <= 8'h00;
			len_q <= 16'h0000;
			tag_q <= 32'h0000_0000;
			drop_q <= 1'b0;
		end
		else if (start)
		begin
			b1_q[`ICHF_B1_VER_MSB:`ICHF_B1_VER_LSB] <= `ICHF_VERSION; // [RL1]
			b1_q[`ICHF_B1_FIXED1] <= 1'b1; // [RL2]
			b1_q[`ICHF_B1_SPARE] <= 1'b1; // [RL2]
			b1_q[`ICHF_B1_ICE] <= META_SERVING_NODE; // [RL10]
			b1_q[`ICHF_B1_DIR] <= META_UPLINK; // [RL3]
			b1_q[`ICHF_B1_FIXED0] <= 1'b0; // [RL2]
			len_q <= META_LENGTH; // [RL5]
			tag_q <= META_BILLING_TAG; // [RL9]
			// udp mode: a fifo full at packet start drops the whole packet rather than stalling
			drop_q <= drop_mode & ~f_ready; // [RL14]
		end
	end

	////////////////////////////////////////////////////////////////
	// header octet selection by index
	always @*
	begin
		case (idx_q)
			5'h00: hdr_byte = b1_q;
			5'h01: hdr_byte = `ICHF_MSG_TYPE; // [RL4]
			5'h02: hdr_byte = len_q[15:8]; // [RL5]
			5'h03: hdr_byte = len_q[7:0]; // [RL5]
			5'h04: hdr_byte = seq_q[15:8]; // [RL6]
			5'h05: hdr_byte = seq_q[7:0]; // [RL6]
			5'h06: hdr_byte = `ICHF_FILL_ZERO; // [RL7]
			5'h07: hdr_byte = `ICHF_FILL_ZERO; // [RL7]
			5'h08: hdr_byte = `ICHF_FILL_ONES; // [RL8]
			5'h09: hdr_byte = `ICHF_FILL_ONES; // [RL8]
			5'h0A: hdr_byte = `ICHF_FILL_ONES; // [RL8]
			5'h0B: hdr_byte = `ICHF_FILL_ONES; // [RL8]
			5'h0C: hdr_byte = node_id[31:24]; // [RL9]
			5'h0D: hdr_byte = node_id[23:16]; // [RL9]
			5'h0E: hdr_byte = node_id[15:8]; // [RL9]
			5'h0F: hdr_byte = node_id[7:0]; // [RL9]
			5'h10: hdr_byte = tag_q[31:24]; // [RL9]
			5'h11: hdr_byte = tag_q[23:16]; // [RL9]
			5'h12: hdr_byte = tag_q[15:8]; // [RL9]
			5'h13: hdr_byte = tag_q[7:0]; // [RL9]
			default: hdr_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// sequencer: idle, header, then one payload ending at in_last
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (start)
					state_d = ST_HDR;
			end
			ST_HDR:
			begin
				if (hdr_step & (idx_q == `ICHF_HDR_LAST))
					state_d = ST_PAY;
			end
			ST_PAY:
			begin
				// one payload element per header, back to idle on its last octet
				if (pay_step & IN_LAST)
					state_d = ST_IDLE; // [RL11]
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge CLOCK)
	begin
		if (RST)
		begin
			state_q <= ST_IDLE;
			idx_q <= 5'h00;
		end
		else if (CE)
		begin
			state_q <= state_d;
			if (start)
				idx_q <= 5'h00;
			else if (hdr_step)
				idx_q <= idx_q + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// sequence number and counters; a software clear as a sent packet completes gives 1, and is lost if that packet is dropped
	always @(posedge CLOCK)
	begin
		if (RST)
		begin
			seq_q <= 16'h0000;
			pkt_count_q <= 32'h0000_0000;
			drop_count_q <= 32'h0000_0000;
		end
		else if (CE)
		begin
			if (pay_step & IN_LAST)
			begin
				if (drop_q)
					drop_count_q <= drop_count_q + 32'h0000_0001;
				else
				begin
					seq_q <= seq_clr ? 16'h0001 : seq_q + 16'h0001; // [RL6]
					pkt_count_q <= pkt_count_q + 32'h0000_0001;
				end
			end
			else if (seq_clr)
				seq_q <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////
	// fifo feed: header octets then the packet copied octet for octet
	always @*
	begin
		f_valid = 1'b0;
		f_data = {1'b0, hdr_byte};
		if (state_q == ST_HDR)
			f_valid = ~drop_q;
		else if (state_q == ST_PAY)
		begin
			f_valid = IN_VALID & ~drop_q;
			f_data = {IN_LAST, IN_DATA}; // [RL12]
		end
	end

	// tcp mode stalls the source; udp drop discards without waiting
	assign IN_READY = CE & (state_q == ST_PAY) & (f_ready | drop_q); // [RL14]

	ichf_fifo #(
		.WIDTH(`ICHF_FIFO_WIDTH),
		.DEPTH(`ICHF_FIFO_DEPTH),
		.AW(`ICHF_FIFO_AW)
	) u_fifo (
		.clk(CLOCK),
		.rst(RST),
		.ce(CE),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.in_data(f_data),
		.out_valid(o_valid),
		.out_ready(OUT_READY),
		.out_data(o_data)
	);

	// framed packets leave toward the transport
	assign OUT_VALID = o_valid; // [RL13]
	assign OUT_DATA = o_data[7:0];
	assign OUT_LAST = o_data[8];
endmodule // ichf_framer
`default_nettype wire

// >>> sim/ichf_framer_assertions.sv
// port-level checks for the correlation header framer
`timescale 1ns/100ps
`default_nettype none
module ichf_framer_assertions (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic IN_READY,
	input wire logic OUT_VALID,
	input wire logic OUT_READY,
	input wire logic [7:0] OUT_DATA,
	input wire logic OUT_LAST,
	input wire logic BUSY
);
	logic [15:0] pos_q;
	// octet position inside the framed packet now leaving
	always @(posedge CLOCK)
	begin
		if (RST || (OUT_VALID && OUT_READY && OUT_LAST))
			pos_q <= 16'h0000;
		else if (OUT_VALID && OUT_READY)
			pos_q <= pos_q + 16'h0001;
	end
	////////////////////////////////////////
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	AST_VERSION: assert property (OUT_VALID && pos_q == 16'h0000 |-> OUT_DATA[7:5] == 3'h0)
		else $error("version field not zero");
	AST_FIXED_BITS: assert property (OUT_VALID && pos_q == 16'h0000 |-> OUT_DATA[4:3] == 2'h3 && !OUT_DATA[0])
		else $error("fixed bits of first octet wrong");
	AST_MSG_TYPE: assert property (OUT_VALID && pos_q == 16'h0001 |-> OUT_DATA == 8'hFF)
		else $error("message type not 255");
	AST_ZERO_FILL: assert property (OUT_VALID && pos_q inside {16'h0006, 16'h0007} |-> OUT_DATA == 8'h00)
		else $error("zero filler wrong");
	AST_ONES_FILL: assert property (OUT_VALID && pos_q inside {[16'h0008:16'h000B]} |-> OUT_DATA == 8'hFF)
		else $error("ones filler wrong");
	AST_ONE_PAYLOAD: assert property (OUT_VALID && OUT_LAST |-> pos_q >= 16'h0014)
		else $error("packet ends inside its header");
	AST_OUT_HOLD: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST))
		else $error("output octet changed while stalled");
	AST_IDLE_NO_INPUT: assert property (!BUSY |-> !IN_READY)
		else $error("payload taken while idle");
	cover property (OUT_VALID && OUT_READY && OUT_LAST);
	cover property (OUT_VALID && !OUT_READY [*4]);
	cover property (IN_READY && BUSY);
endmodule // ichf_framer_assertions
`default_nettype wire

// >>> sim/ichf_sink.sv
// transport-side sink model with random back-pressure
`timescale 1ns/100ps
`default_nettype none
module ichf_sink (
	input wire logic clk,
	input wire logic hold,
	input wire logic out_valid,
	output logic out_ready,
	input wire logic [7:0] out_data,
	input wire logic out_last
);
	logic [7:0] got[$];
	int n_frames = 0;
	initial out_ready = 1'b0;
	////////////////////////////////////////
	// stores octets in arrival order; hold models a dead link that fills the fifo
	always @(posedge clk)
	begin
		out_ready <= !hold && ($urandom % 3 != 0);
		if (out_valid && out_ready)
		begin
			got.push_back(out_data);
			if (out_last)
				n_frames++;
		end
	end
endmodule // ichf_sink
`default_nettype wire

// >>> sim/test_intercept_correlation_header_framer.sv
// self-checking bench for the correlation header framer
`timescale 1ns/100ps
`default_nettype none
`include "ichf_regs.vh"
bind ichf_framer ichf_framer_assertions i_chk (.CLOCK(CLOCK), .RST(RST), .IN_READY(IN_READY),
	.OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST), .BUSY(BUSY));
module test_intercept_correlation_header_framer;
	logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hold = 1'b0;
	logic [7:0] haddr = 8'h00, in_data = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, m_tag = 32'h0, node = 32'h0, rd;
	logic m_up = 1'b0, m_sn = 1'b0, in_valid = 1'b0, in_last = 1'b0;
	logic [15:0] m_len = 16'h0, seq = 16'h0;
	wire [31:0] hrdata;
	wire [7:0] out_data;
	wire hreadyout, hresp, in_ready, out_valid, out_ready, out_last, busy;
	int n_fail = 0, n_tests = 0;
	ichf_framer i_ichf_framer (.CLOCK(clock), .RST(rst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .META_UPLINK(m_up), .META_SERVING_NODE(m_sn),
		.META_LENGTH(m_len), .META_BILLING_TAG(m_tag), .IN_VALID(in_valid), .IN_READY(in_ready),
		.IN_DATA(in_data), .IN_LAST(in_last), .OUT_VALID(out_valid), .OUT_READY(out_ready),
		.OUT_DATA(out_data), .OUT_LAST(out_last), .BUSY(busy));
	ichf_sink i_ichf_sink (.clk(clock), .hold(hold), .out_valid(out_valid), .out_ready(out_ready),
		.out_data(out_data), .out_last(out_last));
	always #5 clock = ~clock;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one single ahb-lite transfer; waits on hready in both phases
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
		chk(hresp, 1'b0);
	endtask
	// expected header octet i, worked out from the metadata in force
	function automatic logic [7:0] hb(input int i);
		case (i)
			0: hb = {3'h0, 2'h3, m_sn, m_up, 1'b0};
			1, 8, 9, 10, 11: hb = 8'hFF;
			2: hb = m_len[15:8];
			3: hb = m_len[7:0];
			4: hb = seq[15:8];
			5: hb = seq[7:0];
			6, 7: hb = 8'h00;
			default: hb = 8'({node, m_tag} >> (8 * (19 - i)));
		endcase
	endfunction
	// sends one random packet and compares the whole framed result
	task automatic pkt;
		int i, n, f0;
		logic [7:0] p[12];
		n = 1 + $urandom % 12;
		f0 = i_ichf_sink.n_frames;
		i_ichf_sink.got.delete();
		m_up <= $urandom;
		m_sn <= $urandom;
		m_tag <= $urandom;
		m_len <= 16'(n);
		for (i = 0; i < n; i++)
		begin
			p[i] = $urandom;
			in_valid <= 1'b1;
			in_data <= p[i];
			in_last <= (i == n - 1);
			do @(negedge clock); while (in_ready !== 1'b1);
			@(posedge clock);
		end
		in_valid <= 1'b0;
		in_last <= 1'b0;
		for (i = 0; i < 600 && i_ichf_sink.n_frames == f0; i++)
			@(posedge clock);
		chk(i_ichf_sink.got.size(), 20 + n);
		chk(i_ichf_sink.n_frames, f0 + 1);
		for (i = 0; i < 20; i++)
			chk(i_ichf_sink.got[i], hb(i));
		for (i = 0; i < n; i++)
			chk(i_ichf_sink.got[20 + i], p[i]);
		seq++;
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		#300000;
		n_fail++;
		test_done;
	end
	initial
	begin
		void'($urandom(32'h0A16A243));
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		ahb(1'b0, `ICHF_REG_CTRL, 32'h0, rd);
		chk(rd, `ICHF_CTRL_RESET);
		ahb(1'b0, `ICHF_REG_NODE_ID, 32'h0, rd);
		chk(rd, `ICHF_NODE_ID_RESET);
		ahb(1'b0, 8'h40, 32'h0, rd);
		chk(rd, 32'h0);
		node = $urandom;
		ahb(1'b1, `ICHF_REG_NODE_ID, node, rd);
		ahb(1'b0, `ICHF_REG_NODE_ID, 32'h0, rd);
		chk(rd, node);
		$display("register test done");
		hold <= 1'b1;
		fork
			pkt();
			begin
				repeat (40) @(posedge clock);
				ahb(1'b0, `ICHF_REG_STATUS, 32'h0, rd);
				chk(rd[2], 1'b0);
				chk(busy, 1'b1);
				hold <= 1'b0;
			end
		join
		ahb(1'b0, `ICHF_REG_STATUS, 32'h0, rd);
		chk(rd[2], 1'b1);
		$display("stall test done");
		repeat (6) pkt();
		$display("stream test done");
		ahb(1'b1, `ICHF_REG_CTRL, 32'h3, rd);
		seq = 16'h0;
		pkt();
		$display("sequence clear test done");
		// udp drop mode with a live sink: nothing may be lost or counted as dropped
		ahb(1'b1, `ICHF_REG_CTRL, 32'h5, rd);
		pkt();
		ahb(1'b0, `ICHF_REG_COUNT, 32'h0, rd);
		chk(rd, 32'h9);
		ahb(1'b0, `ICHF_REG_DROP, 32'h0, rd);
		chk(rd, 32'h0);
		ahb(1'b0, `ICHF_REG_SEQ, 32'h0, rd);
		chk(rd, {16'h0000, seq});
		$display("drop mode test done");
		test_done;
	end
endmodule // test_intercept_correlation_header_framer
`default_nettype wire
